// ===== dpram_port_defs.vh
// pin timing counts and mailbox addresses for the dual-port memory port controller
`ifndef DPRAM_PORT_DEFS_VH
`define DPRAM_PORT_DEFS_VH
`define CLK_PERIOD_NS 20
// cycle-time figures in ns, counts rounded up to whole cycles
`define ACCESS_TIME_NS 25
`define ACCESS_CYCLES ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS 40
`define WRITE_CYCLES ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS 20
`define SETUP_CYCLES ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 3
`define ADDR_W 13
`define DATA_W 9
`define MBOX_ADDR_LEFT 13'h1fff
`define MBOX_ADDR_RIGHT 13'h1ffe
`define OP_RAM_RD 2'h0
`define OP_RAM_WR 2'h1
`define OP_FLAG_RD 2'h2
`define OP_FLAG_WR 2'h3
`endif

// ===== phase_timer.v
// down-counter that marks the end of one bus phase
module phase_timer (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire load_i,
   input wire [2:0] count_i,
   output wire done_o
);
   reg [2:0] cnt_q;
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= 3'h0;
      end else if (load_i) begin
         cnt_q <= count_i;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end
   // done must not look at load: the caller reloads on done, which would close a loop
   assign done_o = (cnt_q == 3'h0);
endmodule // phase_timer

// ===== dpram_port_ctrl.v
// one-port host controller driving the dual-port memory pins
`include "dpram_port_defs.vh"
module dpram_port_ctrl (
   input wire clk_sys_i,
   input wire arst_n_i,
   // user command side
   input wire req_valid_i,
   output wire req_ready_o,
   input wire [1:0] req_op_i,
   input wire [12:0] req_addr_i,
   input wire [8:0] req_wdata_i,
   output reg rsp_valid_o,
   output reg [8:0] rsp_rdata_o,
   output reg rsp_busy_o,
   output wire token_held_o,
   output wire mbox_flag_o,
   // device pins
   output reg [12:0] addr_o,
   output reg select_n_o,
   output reg flag_select_n_o,
   output reg read_write_n_o,
   output reg out_enable_n_o,
   output reg [8:0] data_o,
   output reg data_oe_o,
   input wire [8:0] data_i,
   input wire busy_n_i,
   input wire int_n_i
);
   localparam ST_IDLE = 3'h0;
   localparam ST_SETUP = 3'h1;
   localparam ST_STROBE = 3'h2;
   localparam ST_HOLD = 3'h3;
   localparam ST_VERIFY = 3'h4;

   reg [2:0] state_q;
   reg [1:0] op_q;
   reg [8:0] data_sync1_q, data_sync2_q;
   reg busy_sync1_q, busy_sync2_q;
   reg int_sync1_q, int_sync2_q;
   reg token_q;
   reg busy_seen_q;
   reg tmr_load;
   reg [2:0] tmr_count;
   wire tmr_done;

   function is_write;
      input [1:0] op;
      begin
         is_write = (op == `OP_RAM_WR) || (op == `OP_FLAG_WR);
      end
   endfunction

   // a flag write of 0 is a token request and needs a readback
   function is_flag_req;
      input [1:0] op;
      input bit0;
      begin
         is_flag_req = (op == `OP_FLAG_WR) && !bit0;
      end
   endfunction

   // counts are tiny; only the low three bits reach the timer, on purpose
   function [2:0] cycles3;
      input [31:0] value;
      begin
         cycles3 = value[2:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         data_sync1_q <= 9'h000;
         data_sync2_q <= 9'h000;
         busy_sync1_q <= 1'b1;
         busy_sync2_q <= 1'b1;
         int_sync1_q <= 1'b1;
         int_sync2_q <= 1'b1;
      end else begin
         data_sync1_q <= data_i;
         data_sync2_q <= data_sync1_q;
         busy_sync1_q <= busy_n_i;
         busy_sync2_q <= busy_sync1_q;
         int_sync1_q <= int_n_i;
         int_sync2_q <= int_sync1_q;
      end
   end

   // device mailbox flag is active low; expose it high
   assign mbox_flag_o = !int_sync2_q;
   assign token_held_o = token_q;
   assign req_ready_o = (state_q == ST_IDLE);

   phase_timer u_timer (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .load_i(tmr_load),
      .count_i(tmr_count),
      .done_o(tmr_done)
   );

   always @* begin
      tmr_load = 1'b0;
      tmr_count = 3'h0;
      case (state_q)
         ST_IDLE: begin
            tmr_load = req_valid_i;
            tmr_count = cycles3(`SETUP_CYCLES);
         end
         ST_SETUP: begin
            tmr_load = tmr_done;
            tmr_count = is_write(op_q) ? cycles3(`WRITE_CYCLES) : cycles3(`ACCESS_CYCLES + 32'h2);
         end
         ST_STROBE: begin
            tmr_load = tmr_done;
            tmr_count = cycles3(`SETUP_CYCLES);
         end
         ST_HOLD: begin
            tmr_load = tmr_done && is_flag_req(op_q, data_o[0]);
            tmr_count = cycles3(`ACCESS_CYCLES + 32'h2);
         end
         ST_VERIFY: begin
            tmr_load = 1'b0;
            tmr_count = 3'h0;
         end
         default: begin
            tmr_load = 1'b0;
            tmr_count = 3'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // pin sequencer
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_IDLE;
         op_q <= `OP_RAM_RD;
         addr_o <= 13'h0000;
         select_n_o <= 1'b1;
         flag_select_n_o <= 1'b1;
         read_write_n_o <= 1'b1;
         out_enable_n_o <= 1'b1;
         data_o <= 9'h000;
         data_oe_o <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= 9'h000;
         rsp_busy_o <= 1'b0;
         token_q <= 1'b0;
         busy_seen_q <= 1'b0;
      end else begin
         rsp_valid_o <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (req_valid_i) begin
                  // address moves only while read_write_n is high
                  read_write_n_o <= 1'b1;
                  addr_o <= req_addr_i;
                  op_q <= req_op_i;
                  data_o <= req_wdata_i;
                  busy_seen_q <= 1'b0;
                  // memory cycles use select, flag cycles flag select, never both
                  select_n_o <= req_op_i[1];
                  flag_select_n_o <= !req_op_i[1];
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (tmr_done) begin
                  if (is_write(op_q)) begin
                     // write pulse lies inside the select window
                     read_write_n_o <= 1'b0;
                     data_oe_o <= 1'b1;
                     out_enable_n_o <= 1'b1;
                  end else begin
                     out_enable_n_o <= 1'b0;
                  end
                  state_q <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (!busy_sync2_q) begin
                  // busy goes to one port only; the loser's write is void
                  busy_seen_q <= 1'b1;
               end
               if (tmr_done) begin
                  read_write_n_o <= 1'b1;
                  out_enable_n_o <= 1'b1;
                  rsp_rdata_o <= data_sync2_q;
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (tmr_done) begin
                  data_oe_o <= 1'b0;
                  if (is_flag_req(op_q, data_o[0])) begin
                     // request written: read it back, 0 means granted
                     read_write_n_o <= 1'b1;
                     out_enable_n_o <= 1'b0;
                     state_q <= ST_VERIFY;
                  end else begin
                     select_n_o <= 1'b1;
                     flag_select_n_o <= 1'b1;
                     if (op_q == `OP_FLAG_WR) begin
                        // release frees it or hands it over
                        token_q <= 1'b0;
                     end
                     rsp_valid_o <= 1'b1;
                     rsp_busy_o <= busy_seen_q || !busy_sync2_q;
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_VERIFY: begin
               if (tmr_done) begin
                  out_enable_n_o <= 1'b1;
                  flag_select_n_o <= 1'b1;
                  // failed if still 1: another port holds it or won contention
                  token_q <= !data_sync2_q[0];
                  rsp_rdata_o <= data_sync2_q;
                  rsp_busy_o <= busy_seen_q;
                  rsp_valid_o <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // dpram_port_ctrl

// ===== dpram_port_ctrl_chk.sv
// pin order and answer timing assertions for the port controller
module dpram_port_ctrl_chk (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire req_valid_i,
   input wire req_ready_o,
   input wire rsp_valid_o,
   input wire [12:0] addr_o,
   input wire select_n_o,
   input wire flag_select_n_o,
   input wire read_write_n_o,
   input wire out_enable_n_o,
   input wire data_oe_o,
   input wire int_n_i,
   input wire mbox_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   property p_addr_rw; !$stable(addr_o) |-> read_write_n_o && $past(read_write_n_o); endproperty
   a_addr_rw: assert property (p_addr_rw) else $error("address moved during write");
   property p_one_space; !(!select_n_o && !flag_select_n_o); endproperty
   a_one_space: assert property (p_one_space) else $error("both selects low");
   property p_wr_drive; !read_write_n_o |-> data_oe_o && (!select_n_o || !flag_select_n_o); endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("write without data or select");
   property p_rd_float; !out_enable_n_o |-> !data_oe_o && read_write_n_o; endproperty
   a_rd_float: assert property (p_rd_float) else $error("read while driving");
   property p_wr_len; $fell(read_write_n_o) |=> !read_write_n_o; endproperty
   a_wr_len: assert property (p_wr_len) else $error("write pulse too short");
   property p_flag_set; !int_n_i [*4] |-> mbox_flag_o; endproperty
   a_flag_set: assert property (p_flag_set) else $error("mailbox flag missed");
   property p_flag_clr; int_n_i [*4] |-> !mbox_flag_o; endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("mailbox flag stuck");
   property p_answer; req_valid_i && req_ready_o |-> ##[4:30] rsp_valid_o; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   c_flag_wr: cover property (!flag_select_n_o && !read_write_n_o);
   c_ram_rd: cover property (!select_n_o && !out_enable_n_o);
   c_flag: cover property ($rose(mbox_flag_o));
endmodule // dpram_port_ctrl_chk

bind dpram_port_ctrl dpram_port_ctrl_chk i_dpram_port_ctrl_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
   .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .addr_o(addr_o),
   .select_n_o(select_n_o), .flag_select_n_o(flag_select_n_o), .read_write_n_o(read_write_n_o),
   .out_enable_n_o(out_enable_n_o), .data_oe_o(data_oe_o), .int_n_i(int_n_i), .mbox_flag_o(mbox_flag_o));

// ===== dpram_dev_model.sv
// behavioural device: left-port pins, right port as stand-in levels
module dpram_dev_model (
   input wire [12:0] addr_i,
   input wire sel_n_i,
   input wire flag_sel_n_i,
   input wire rw_n_i,
   input wire oe_n_i,
   input wire [8:0] wd_i,
   input wire r_req_i,
   input wire mb_set_i,
   output wire [8:0] rd_o,
   output reg int_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [8:0] mem_q [0:8191];
   reg lhold_q = 1'b0;
   wire [8:0] v = !sel_n_i ? mem_q[addr_i] : {9{!lhold_q}};
   wire drv = rw_n_i && !oe_n_i && (sel_n_i ^ flag_sel_n_i);
   // released lines show the inverse, never a stale copy
   assign rd_o = drv ? v : ~v;
   initial int_n_o = 1'b1;
   always @(posedge rw_n_i) begin
      if (!sel_n_i && flag_sel_n_i) mem_q[addr_i] = wd_i;
      // right holds while r_req_i is up and left does not
      if (sel_n_i && !flag_sel_n_i) lhold_q = !wd_i[0] && (!r_req_i || lhold_q);
   end
   always @(posedge mb_set_i) int_n_o = 1'b0;
   always @(negedge oe_n_i) if (!sel_n_i && addr_i == 13'h1ffe) int_n_o = 1'b1;
endmodule // dpram_dev_model

// ===== tb_top.sv
// self-checking bench for the one-port dual-port memory controller
`include "dpram_port_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   reg clk_sys_i = 1'b0, arst_n_i = 1'b0, req_valid_i = 1'b0, r_req = 1'b0, mb_set = 1'b0, busy_n_i = 1'b1;
   reg [1:0] req_op_i = 2'h0;
   reg [12:0] req_addr_i = 13'h0000, a, addr_q [0:15];
   reg [8:0] req_wdata_i = 9'h000, shadow [0:8191];
   reg [15:0] lfsr_q = 16'h0048;
   integer mismatches = 0, num_checks = 0, i, n;
   wire req_ready_o, rsp_valid_o, rsp_busy_o, token_held_o, mbox_flag_o, select_n_o, flag_select_n_o;
   wire read_write_n_o, out_enable_n_o, data_oe_o, int_n_i;
   wire [8:0] rsp_rdata_o, data_o, data_i;
   wire [12:0] addr_o;
   dpram_port_ctrl i_dpram_port_ctrl (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_busy_o(rsp_busy_o), .token_held_o(token_held_o),
      .mbox_flag_o(mbox_flag_o), .addr_o(addr_o), .select_n_o(select_n_o), .flag_select_n_o(flag_select_n_o),
      .read_write_n_o(read_write_n_o), .out_enable_n_o(out_enable_n_o), .data_o(data_o), .data_oe_o(data_oe_o),
      .data_i(data_i), .busy_n_i(busy_n_i), .int_n_i(int_n_i));
   dpram_dev_model i_dpram_dev_model (.addr_i(addr_o), .sel_n_i(select_n_o), .flag_sel_n_i(flag_select_n_o),
      .rw_n_i(read_write_n_o), .oe_n_i(out_enable_n_o), .wd_i(data_oe_o ? data_o : ~data_o),
      .r_req_i(r_req), .mb_set_i(mb_set), .rd_o(data_i), .int_n_o(int_n_i));
   initial forever #10 clk_sys_i = ~clk_sys_i;
   ////////////////////////////////////////////////////////////////
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // memory keeps the last word written to each address
   function [8:0] exp_ram(input [12:0] ad);
      exp_ram = shadow[ad];
   endfunction
   task chk(input [8:0] seen, input [8:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   // sampling on the falling edge keeps clear of the design's own updates
   task cmd(input [1:0] op, input [12:0] ad, input [8:0] d);
      begin
         @(posedge clk_sys_i);
         req_op_i <= op;
         req_addr_i <= ad;
         req_wdata_i <= d;
         req_valid_i <= 1'b1;
         @(negedge clk_sys_i);
         while (req_ready_o !== 1'b1) @(negedge clk_sys_i);
         @(posedge clk_sys_i);
         req_valid_i <= 1'b0;
         n = 0;
         @(negedge clk_sys_i);
         while (rsp_valid_o !== 1'b1 && n < 60) begin
            n = n + 1;
            @(negedge clk_sys_i);
         end
         if (rsp_valid_o !== 1'b1) chk(9'h001, 9'h000);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      mismatches = mismatches + 1;
      give_verdict;
   end
   initial begin
      repeat (16) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
         lfsr_q = lfsr(lfsr_q);
         a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : lfsr_q[12:0];
         addr_q[i] = a;
         shadow[a] = lfsr_q[15:7];
         @(posedge clk_sys_i);
         busy_n_i <= (i != 5);
         cmd(`OP_RAM_WR, a, lfsr_q[15:7]);
         chk({8'h00, rsp_busy_o}, {8'h00, i == 5});
      end
      for (i = 0; i < 16; i = i + 1) begin
         cmd(`OP_RAM_RD, addr_q[i], 9'h000);
         chk(rsp_rdata_o, exp_ram(addr_q[i]));
      end
      cmd(`OP_FLAG_RD, 13'h0003, 9'h000);
      chk({8'h00, rsp_rdata_o[0]}, 9'h001);
      cmd(`OP_FLAG_WR, 13'h0003, 9'h000);
      chk({8'h00, rsp_rdata_o[0]}, 9'h000);
      chk({8'h00, token_held_o}, 9'h001);
      r_req <= 1'b1;
      cmd(`OP_FLAG_WR, 13'h0003, 9'h001);
      chk({8'h00, token_held_o}, 9'h000);
      cmd(`OP_FLAG_WR, 13'h0003, 9'h000);
      chk({8'h00, rsp_rdata_o[0]}, 9'h001);
      chk({8'h00, token_held_o}, 9'h000);
      r_req <= 1'b0;
      cmd(`OP_FLAG_RD, 13'h0003, 9'h000);
      chk({8'h00, rsp_rdata_o[0]}, 9'h001);
      mb_set <= 1'b1;
      repeat (6) @(negedge clk_sys_i);
      chk({8'h00, mbox_flag_o}, 9'h001);
      mb_set <= 1'b0;
      cmd(`OP_RAM_RD, 13'h1ffe, 9'h000);
      repeat (6) @(negedge clk_sys_i);
      chk({8'h00, mbox_flag_o}, 9'h000);
      give_verdict;
   end
endmodule // tb_top
